/* logic/dbgev_top.sv */
// debug event detect and record: trap, branch taken, instruction complete, interrupt taken
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dbgev_params.svh"

module dbgev_top
   import dbgev_pkg::*;
#(
   parameter int HV_EN = 1,
   parameter int DELAYED_EN = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // core state
   input wire logic guest_state_i,
   input wire logic debug_unavailable_hv_i,
   input wire dbgev_retire_s rv_i,
   input wire dbgev_irq_s irq_i,
   // exception requests to the core
   output logic suppress_o,
   output logic dbg_int_o,
   output logic [63:0] dbg_pc_o,
   output logic prog_trap_o
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (HV_EN < 0 || HV_EN > 1) begin : g_bad_hv
      $error("HV_EN must be 0 or 1");
   end
   if (DELAYED_EN < 0 || DELAYED_EN > 1) begin : g_bad_dly
      $error("DELAYED_EN must be 0 or 1");
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [4:0] debug_control_0;
   logic [4:0] debug_status;
   logic [63:0] debug_save_pc;
   logic wb_req;
   logic wb_wr;
   logic [4:0] stat_clr;
   logic [4:0] stat_set;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
   assign stat_clr = (wb_wr && wb_adr_i == `DBGEV_OFS_STAT) ? wb_dat_i[4:0] : 5'h00;

   // ----------------------------------------------------------------
   // condition detection
   // ----------------------------------------------------------------
   logic hv_block;
   logic internal_debug_mode;
   logic de;
   logic c_trap;
   logic c_brt;
   logic c_instr_complete_event;
   logic c_interrupt_taken_event;
   logic armed;
   logic any_c;
   logic delay_rec;
   logic pending;
   logic delay_fire;
   logic imm_fire;

   assign internal_debug_mode = debug_control_0[`DBGEV_B_IDM];
   // de as held at the start of the instruction, not the value it writes
   assign de = rv_i.de_start;

   assign hv_block = (HV_EN != 0) && !guest_state_i && debug_unavailable_hv_i;

   assign c_trap = debug_control_0[`DBGEV_B_TRAP] && rv_i.valid && rv_i.trap_met
                   && !hv_block;

   assign c_brt = debug_control_0[`DBGEV_B_BRT] && de && rv_i.valid
                  && rv_i.branch_taken && !hv_block;

   // system call finishes before its own interrupt, so it still counts
   assign c_instr_complete_event = debug_control_0[`DBGEV_B_INSTR_COMPLETE_EVENT] && de && rv_i.valid
                   && (rv_i.complete || rv_i.syscall)
                   && !rv_i.other_exc && !hv_block;

   // only base class interrupts count
   assign c_interrupt_taken_event = debug_control_0[`DBGEV_B_INTERRUPT_TAKEN_EVENT] && irq_i.taken
                   && irq_i.cls == DBGEV_CLS_BASE && !hv_block;

   assign any_c = c_trap || c_brt || c_instr_complete_event || c_interrupt_taken_event;

   assign armed = internal_debug_mode && de && !rv_i.higher_prio;

   assign imm_fire = armed && any_c;

   // branch and complete never reach this path: too frequent to log
   assign delay_rec = (DELAYED_EN != 0) && internal_debug_mode && !de
                      && (c_trap || c_interrupt_taken_event);

   assign pending = debug_status[`DBGEV_B_IDE]
                    && (debug_status[`DBGEV_B_TRAP] || debug_status[`DBGEV_B_INTERRUPT_TAKEN_EVENT]);

   // a return that raises de fires a pending event at once, saving its next pc
   assign delay_fire = (DELAYED_EN != 0) && internal_debug_mode && pending && rv_i.valid
                       && !rv_i.de_start && rv_i.de_new;

   // instruction-bound events suppress the excepting instruction
   assign suppress_o = armed && (c_trap || c_brt || c_instr_complete_event);

   // ----------------------------------------------------------------
   // status set terms
   // ----------------------------------------------------------------
   always_comb begin
      stat_set = 5'h00;
      if (armed) begin
         stat_set[`DBGEV_B_TRAP] = c_trap;
         stat_set[`DBGEV_B_BRT] = c_brt;
         stat_set[`DBGEV_B_INSTR_COMPLETE_EVENT] = c_instr_complete_event;
         stat_set[`DBGEV_B_INTERRUPT_TAKEN_EVENT] = c_interrupt_taken_event;
      end
      if (delay_rec) begin
         stat_set[`DBGEV_B_TRAP] = c_trap;
         stat_set[`DBGEV_B_INTERRUPT_TAKEN_EVENT] = c_interrupt_taken_event;
         stat_set[`DBGEV_B_IDE] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         debug_control_0 <= `DBGEV_CTRL_RST;
      end else if (wb_wr && wb_adr_i == `DBGEV_OFS_CTRL) begin
         debug_control_0 <= wb_dat_i[4:0];
      end
   end

   // ----------------------------------------------------------------
   // status register: set wins over a same-cycle clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         debug_status <= `DBGEV_STAT_RST;
      end else begin
         debug_status <= (debug_status & ~stat_clr) | stat_set;
      end
   end

   // ----------------------------------------------------------------
   // debug interrupt and save address
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dbg_int_o <= 1'b0;
      end else begin
         dbg_int_o <= imm_fire || delay_fire;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         debug_save_pc <= 64'h0000000000000000;
      end else if (imm_fire && !(c_trap || c_brt || c_instr_complete_event)) begin
         debug_save_pc <= irq_i.handler_pc;
      end else if (imm_fire) begin
         debug_save_pc <= rv_i.pc;
      end else if (delay_fire) begin
         debug_save_pc <= rv_i.next_pc;
      end
   end

   assign dbg_pc_o = debug_save_pc;

   // trap seen with debug masked becomes an ordinary program trap
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prog_trap_o <= 1'b0;
      end else begin
         prog_trap_o <= internal_debug_mode && !de && c_trap;
      end
   end

   // ----------------------------------------------------------------
   // wishbone answer: ack one cycle after the request
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (wb_req && !wb_we_i) begin
         if (wb_adr_i == `DBGEV_OFS_CTRL) begin
            wb_dat_o <= {27'h0000000, debug_control_0};
         end else if (wb_adr_i == `DBGEV_OFS_STAT) begin
            wb_dat_o <= {27'h0000000, debug_status};
         end else if (wb_adr_i == `DBGEV_OFS_SPCL) begin
            wb_dat_o <= debug_save_pc[31:0];
         end else if (wb_adr_i == `DBGEV_OFS_SPCH) begin
            wb_dat_o <= debug_save_pc[63:32];
         end else begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_hv_suppress: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (hv_block && !delay_fire && stat_clr == 5'h00)
      |=> !dbg_int_o && !prog_trap_o && !$changed(debug_status[3:0]))
      else $error("event seen while hypervisor reserves debug");

   a_trap_immediate: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (armed && c_trap) |=> dbg_int_o && dbg_pc_o == $past(rv_i.pc)
                            && debug_status[`DBGEV_B_TRAP])
      else $error("trap with de did not interrupt at its own address");

   a_prog_trap: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (internal_debug_mode && !de && c_trap && !delay_fire) |=> prog_trap_o && !dbg_int_o)
      else $error("masked trap did not become program trap");

   a_delay_record: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (DELAYED_EN != 0 && internal_debug_mode && !de && c_interrupt_taken_event && !delay_fire)
      |=> debug_status[`DBGEV_B_INTERRUPT_TAKEN_EVENT] && debug_status[`DBGEV_B_IDE] && !dbg_int_o)
      else $error("delayed interrupt taken event not recorded");

   a_brt_unarmed: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!de && rv_i.valid && rv_i.branch_taken && !debug_status[`DBGEV_B_BRT]
       && !(internal_debug_mode && (c_trap || c_interrupt_taken_event)))
      |=> !debug_status[`DBGEV_B_BRT] && !$rose(debug_status[`DBGEV_B_IDE]))
      else $error("branch taken recorded while unarmed");

   a_instr_complete_event_other: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rv_i.other_exc && !rv_i.trap_met && !rv_i.branch_taken && !irq_i.taken)
      |-> !suppress_o ##1 !dbg_int_o || $past(delay_fire))
      else $error("suppressed instruction raised complete event");

   a_delay_fire: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (delay_fire && !imm_fire) |=> dbg_int_o && dbg_pc_o == $past(rv_i.next_pc))
      else $error("delayed interrupt missing or wrong address");

   a_status_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (debug_status[`DBGEV_B_IDE] && !stat_clr[`DBGEV_B_IDE])
      |=> debug_status[`DBGEV_B_IDE])
      else $error("status bit lost without a clear");

   a_interrupt_taken_event_class: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (irq_i.taken && irq_i.cls != DBGEV_CLS_BASE && !(c_trap || c_brt || c_instr_complete_event)
       && !delay_fire)
      |=> !dbg_int_o && !$rose(debug_status[`DBGEV_B_INTERRUPT_TAKEN_EVENT]))
      else $error("non-base interrupt raised interrupt taken event");

   a_interrupt_taken_event_handler: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (armed && c_interrupt_taken_event && !rv_i.trap_met && !c_brt && !c_instr_complete_event)
      |=> dbg_int_o && dbg_pc_o == $past(irq_i.handler_pc))
      else $error("interrupt taken event saved wrong address");

   a_ack_single: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");

endmodule

`default_nettype wire

/* inc/dbgev_params.svh */
// offsets, field positions, reset values and the rule overview for the debug event block
// Overview of operation
// - trap condition: enable set, trap instruction fires
// - guest_state 0, debug_unavailable_hv 1 suppresses all (code: a pending delayed event still fires)
// - idm, de, top priority: record status bit
// - trap with idm, no de: program trap
// - delayed support: trap/interrupt_taken_event set bit and ide
// - trap/brt/instr_complete_event with de: immediate, suppress, save pc
// - delayed exception lets instruction complete
// - pending bit when de set: interrupt, next pc
// - branch taken condition needs enable and de
// - branch taken recorded only armed, never ide
// - instruction complete condition needs enable and de
// - suppressed instruction gives no complete event
// - system call counts as completed
// - complete recorded only armed, never ide
// - return/mtmsr use de from instruction start
// - return enabling de: step after next instruction
// - interrupt taken condition: base class interrupt
// - interrupt taken with de: save handler address
// - critical, debug, machine check never count
`ifndef DBGEV_PARAMS_SVH
`define DBGEV_PARAMS_SVH

`define DBGEV_OFS_CTRL 8'h00
`define DBGEV_OFS_STAT 8'h04
`define DBGEV_OFS_SPCL 8'h08
`define DBGEV_OFS_SPCH 8'h0C

`define DBGEV_B_TRAP 0
`define DBGEV_B_BRT 1
`define DBGEV_B_INSTR_COMPLETE_EVENT 2
`define DBGEV_B_INTERRUPT_TAKEN_EVENT 3
`define DBGEV_B_IDM 4
`define DBGEV_B_IDE 4

`define DBGEV_CTRL_RST 5'h00
`define DBGEV_STAT_RST 5'h00

`endif

/* inc/dbgev_pkg.sv */
// types shared by the debug event block
package dbgev_pkg;

   typedef enum logic [1:0] {
      DBGEV_CLS_BASE = 2'h0,
      DBGEV_CLS_CRIT = 2'h1,
      DBGEV_CLS_DBG = 2'h2,
      DBGEV_CLS_MCHK = 2'h3
   } dbgev_cls_e;

   typedef struct packed {
      logic valid;
      logic [63:0] pc;
      logic [63:0] next_pc;
      logic trap_met;
      logic branch_taken;
      logic complete;
      logic other_exc;
      logic syscall;
      logic de_start;
      logic de_new;
      logic higher_prio;
   } dbgev_retire_s;

   typedef struct packed {
      logic taken;
      dbgev_cls_e cls;
      logic [63:0] handler_pc;
   } dbgev_irq_s;

endpackage

/* tb/dbgev_top_tb.sv */
// self-checking testbench for the debug event detect and record block
`timescale 1ns/1ps
`default_nettype none
`include "dbgev_params.svh"
module dbgev_top_tb;
   import dbgev_pkg::*;
   // ----------------------------------------
   // signals and table
   // ----------------------------------------
   typedef struct packed {
      logic [4:0] ctrl;
      logic [4:0] ev;
      logic dbg_en;
      logic blk;
      logic [2:0] ex;
      logic [4:0] st;
   } dbgev_row_s;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic guest_state_i, debug_unavailable_hv_i, suppress_o, dbg_int_o, prog_trap_o;
   logic [63:0] dbg_pc_o;
   dbgev_retire_s rv_i;
   dbgev_irq_s irq_i;
   dbgev_row_s rows [10];
   int errors = 0;
   int n_checks = 0;
   dbgev_top #(.HV_EN(1), .DELAYED_EN(1)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .guest_state_i(guest_state_i), .debug_unavailable_hv_i(debug_unavailable_hv_i),
      .rv_i(rv_i), .irq_i(irq_i), .suppress_o(suppress_o), .dbg_int_o(dbg_int_o),
      .dbg_pc_o(dbg_pc_o), .prog_trap_o(prog_trap_o));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   // waits on ack for up to 50 cycles; the slave decides the latency
   task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [3:0] sel,
         input logic [31:0] wd);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= wd;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      if (n == 50) errors++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic wb_rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      wb_xfer(adr, 1'b0, 4'hF, 32'h0);
      chk("read data", 64'(rd), 64'(exp));
   endtask
   // one instruction or interrupt, then the registered answer a cycle later
   task automatic step(input dbgev_retire_s r, input dbgev_irq_s q, input logic [2:0] ex,
         input logic [63:0] pc);
      @(posedge clk_i);
      rv_i <= r;
      irq_i <= q;
      #1;
      chk("suppress", 64'(suppress_o), 64'(ex[2]));
      @(posedge clk_i);
      rv_i <= '0;
      irq_i <= '0;
      #1;
      chk("dbg_int", 64'(dbg_int_o), 64'(ex[1]));
      chk("prog_trap", 64'(prog_trap_o), 64'(ex[0]));
      if (ex[1]) chk("dbg_pc", dbg_pc_o, pc);
   endtask
   function automatic dbgev_retire_s mk(input logic [4:0] ev, input logic ds, input logic dn,
         input logic [63:0] pc);
      dbgev_retire_s r;
      r = '0;
      r.valid = 1'b1;
      {r.trap_met, r.branch_taken, r.complete, r.other_exc, r.syscall} = ev;
      r.de_start = ds;
      r.de_new = dn;
      r.pc = pc;
      r.next_pc = pc + 64'h4;
      return r;
   endfunction
   function automatic dbgev_irq_s iq(input dbgev_cls_e c, input logic [63:0] h);
      return '{taken: 1'b1, cls: c, handler_pc: h};
   endfunction
   // ----------------------------------------
   // clock, watchdog, sequence
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      close_out();
   end
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      rst_i = 1'b1;
      guest_state_i = 1'b1;
      debug_unavailable_hv_i = 1'b0;
      rv_i = '0;
      irq_i = '0;
      // ev bits: trap, branch, complete, other exception, system call; ex: sup, int, prog
      rows[0] = '{5'h1F, 5'h10, 1, 0, 3'h6, 5'h01};
      rows[1] = '{5'h1F, 5'h10, 0, 0, 3'h1, 5'h11};
      rows[2] = '{5'h1E, 5'h10, 1, 0, 3'h0, 5'h00};
      rows[3] = '{5'h1F, 5'h08, 1, 0, 3'h6, 5'h02};
      rows[4] = '{5'h1F, 5'h08, 0, 0, 3'h0, 5'h00};
      rows[5] = '{5'h1F, 5'h04, 1, 0, 3'h6, 5'h04};
      rows[6] = '{5'h1F, 5'h04, 0, 0, 3'h0, 5'h00};
      rows[7] = '{5'h1F, 5'h06, 1, 0, 3'h0, 5'h00};
      rows[8] = '{5'h1F, 5'h05, 1, 0, 3'h6, 5'h04};
      rows[9] = '{5'h1F, 5'h10, 1, 1, 3'h0, 5'h00};
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         wb_xfer(`DBGEV_OFS_STAT, 1'b1, 4'hF, 32'h1F);
         wb_xfer(`DBGEV_OFS_CTRL, 1'b1, 4'hF, {27'h0, rows[i].ctrl});
         guest_state_i <= !rows[i].blk;
         debug_unavailable_hv_i <= rows[i].blk;
         step(mk(rows[i].ev, rows[i].dbg_en, rows[i].dbg_en, 64'h1000 + 64'(i * 4)), '0,
            rows[i].ex, 64'h1000 + 64'(i * 4));
         wb_rd_chk(`DBGEV_OFS_STAT, {27'h0, rows[i].st});
      end
      guest_state_i <= 1'b1;
      debug_unavailable_hv_i <= 1'b0;
      $display("test table done");
      // second reset in mid-run clears the saved address and registers
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("dbg_pc after reset", dbg_pc_o, 64'h0);
      wb_rd_chk(`DBGEV_OFS_CTRL, 32'h0);
      wb_rd_chk(`DBGEV_OFS_STAT, 32'h0);
      wb_xfer(8'h10, 1'b1, 4'hF, 32'hFFFF_FFFF);
      wb_rd_chk(8'h10, 32'h0);
      wb_xfer(`DBGEV_OFS_SPCL, 1'b1, 4'hF, 32'h1234_5678);
      wb_rd_chk(`DBGEV_OFS_SPCL, 32'h0);
      wb_xfer(`DBGEV_OFS_CTRL, 1'b1, 4'h0, 32'h1F);
      wb_rd_chk(`DBGEV_OFS_CTRL, 32'h0);
      $display("test reset and bus done");
      // base class interrupt with debug enabled: handler address saved
      wb_xfer(`DBGEV_OFS_CTRL, 1'b1, 4'hF, 32'h1F);
      step(mk(5'h0, 1, 1, 64'h2000), iq(DBGEV_CLS_BASE, 64'hABCD_0000_0000_0500), 3'h2,
         64'hABCD_0000_0000_0500);
      wb_rd_chk(`DBGEV_OFS_STAT, 32'h08);
      wb_rd_chk(`DBGEV_OFS_SPCL, 32'h0000_0500);
      wb_rd_chk(`DBGEV_OFS_SPCH, 32'hABCD_0000);
      for (int c = 1; c < 4; c++) begin
         wb_xfer(`DBGEV_OFS_STAT, 1'b1, 4'hF, 32'h1F);
         step(mk(5'h0, 1, 1, 64'h2100), iq(dbgev_cls_e'(c), 64'h600), 3'h0, 64'h0);
         wb_rd_chk(`DBGEV_OFS_STAT, 32'h0);
      end
      $display("test interrupt taken done");
      // delayed exception stays pending until debug is enabled again
      wb_xfer(`DBGEV_OFS_STAT, 1'b1, 4'hF, 32'h1F);
      step(mk(5'h0, 0, 0, 64'h3000), iq(DBGEV_CLS_BASE, 64'h700), 3'h0, 64'h0);
      for (int k = 0; k < 3; k++) begin
         step(mk(5'h0, 0, 0, 64'h3004 + 64'(k * 4)), '0, 3'h0, 64'h0);
      end
      wb_rd_chk(`DBGEV_OFS_STAT, 32'h18);
      step(mk(5'h0, 0, 1, 64'h3100), '0, 3'h2, 64'h3104);
      wb_xfer(`DBGEV_OFS_STAT, 1'b1, 4'hF, 32'h1F);
      wb_rd_chk(`DBGEV_OFS_STAT, 32'h0);
      $display("test delayed done");
      // return that turns debug on: step lands after the next instruction
      step(mk(5'h04, 0, 1, 64'h4000), '0, 3'h0, 64'h0);
      step(mk(5'h04, 1, 1, 64'h4100), '0, 3'h6, 64'h4100);
      wb_rd_chk(`DBGEV_OFS_STAT, 32'h04);
      $display("test single step done");
      close_out();
   end
endmodule
`default_nettype wire
